//--- shared/sleep_idle_power_manager_map.svh
// Register offsets, field positions, reset values and codes for the power manager.
// Assumes a 32-bit AHB-Lite slave port and one 10 MHz system clock.
`ifndef SLEEP_IDLE_POWER_MANAGER_MAP_SVH
`define SLEEP_IDLE_POWER_MANAGER_MAP_SVH

// Byte offsets of the registers
`define RESET_CONTROL_OFS    8'h00
`define OSC_CONTROL_OFS      8'h04
`define POWER_CONFIG_OFS     8'h08
`define TIMER_ONE_CONTROL_OFS 8'h0c
`define PERIPH_STOP_OFS      8'h10
`define POWER_STATUS_OFS     8'h14

// Field positions
`define REG_KEEP_BIT         8
`define NEW_OSC_LSB          8
`define NEW_OSC_MSB          10
`define CUR_OSC_LSB          0
`define CUR_OSC_MSB          2
`define CLK_LOCK_BIT         7
`define LP_REG_EN_BIT        0
`define WDT_EN_BIT           1
`define CLK_MON_EN_BIT       2
`define TIMER_ONE_STOP_BIT   13
`define STAT_STATE_LSB       0
`define STAT_STATE_MSB       2
`define STAT_OSC_LSB         4
`define STAT_OSC_MSB         6
`define STAT_WAKE_IRQ_BIT    8
`define STAT_WAKE_WDT_BIT    9
`define STAT_LAST_SLEEP_BIT  10

// Reset values
`define OSC_RESET            3'h0
`define WORD_ZERO            32'h0000_0000

// Power-save operand codes
`define SLEEP_OPERAND        8'h00
`define IDLE_OPERAND         8'h01

// Wake-up delay from Sleep or Idle, in system clock cycles
`define WAKE_MIN_CYCLES      2
`define WAKE_MAX_CYCLES      4
`define WAKE_DEF_CYCLES      3

// AHB transfer type bit that marks NONSEQ or SEQ
`define HTRANS_ACTIVE_BIT    1

`endif

//--- shared/sleep_idle_power_manager_pkg.sv
// Types shared by the power manager modules.
// Assumes nothing beyond the map header for numeric constants.
package sleep_idle_power_manager_pkg;

   // Power state of the core clock controller
   typedef enum logic [2:0]
   {
      ST_RUN   = 3'b000,
      ST_ENTER = 3'b001,
      ST_SLEEP = 3'b010,
      ST_IDLE  = 3'b011,
      ST_WAKE  = 3'b100
   } power_state_e;

endpackage : sleep_idle_power_manager_pkg

//--- rtl/wake_delay_timer.sv
// Counts the wake-up delay before the CPU clock is handed back.
// Assumes start_i is a one-cycle pulse and is not repeated while busy.
`timescale 1ns/1ps
module wake_delay_timer
#(
   parameter int CYCLES = 3
)
(
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic start_i,
   output logic      done_o
);

   localparam int CW = $clog2(CYCLES + 1);

   logic          busy_reg;
   logic [CW-1:0] count_reg;
   logic          last_w;

   // Elaboration check: a zero-cycle delay has no final count
   if (CYCLES < 1)
   begin : g_bad_cycles
      $error("wake_delay_timer: CYCLES must be at least 1");
   end

   // Final cycle of the delay
   assign last_w = busy_reg && (count_reg == CW'(CYCLES - 1));
   assign done_o = last_w;

   // Counter runs only while busy; done ends the run
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         busy_reg  <= 1'b0;
         count_reg <= '0;
      end
      else if (start_i)
      begin
         busy_reg  <= 1'b1;
         count_reg <= '0;
      end
      else if (last_w)
      begin
         busy_reg <= 1'b0;
      end
      else if (busy_reg)
      begin
         count_reg <= count_reg + CW'(1);
      end
   end

endmodule : wake_delay_timer

//--- rtl/sleep_idle_power_manager.sv
// Sleep and Idle power-mode manager with its AHB-Lite register slave.
// Assumes the core pulses power_save_instr_i for one cycle per executed
// power-save instruction and presents already-enabled interrupts on irq_wake_i.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sleep_idle_power_manager_map.svh"
module sleep_idle_power_manager
#(
   parameter int         NUM_PERIPH  = 8,
   parameter int         WAKE_CYCLES = `WAKE_DEF_CYCLES,
   parameter logic [7:0] ONCHIP_OSC  = 8'hff  // Sources that are on-chip oscillators
)
(
   input  wire logic                  sys_clk_i,
   input  wire logic                  rstn_i,
   // AHB-Lite slave
   input  wire logic                  hsel_i,
   input  wire logic [31:0]           haddr_i,
   input  wire logic [1:0]            htrans_i,
   input  wire logic                  hwrite_i,
   input  wire logic [2:0]            hsize_i,
   input  wire logic [31:0]           hwdata_i,
   input  wire logic                  hready_i,
   output logic                       hreadyout_o,
   output logic                       hresp_o,
   output logic [31:0]                hrdata_o,
   // Core side
   input  wire logic                  power_save_instr_i,
   input  wire logic [7:0]            power_save_operand_i,
   input  wire logic                  irq_wake_i,
   input  wire logic                  wdt_timeout_i,
   output logic                       irq_hold_o,
   output logic                       core_halted_o,
   output logic                       cpu_clk_en_o,
   // Clock tree, regulators and peripherals
   input  wire logic [NUM_PERIPH-1:0] ext_clk_periph_i,
   output logic                       sys_clk_en_o,
   output logic                       osc_en_o,
   output logic [2:0]                 osc_select_o,
   output logic                       clock_fail_monitor_en_o,
   output logic                       low_power_rc_clock_en_o,
   output logic                       wdt_clear_o,
   output logic [NUM_PERIPH-1:0]      periph_clk_en_o,
   output logic                       regulator_standby_o,
   output logic                       low_power_regulator_o
);

   // Refuse settings the logic cannot serve; caught at elaboration, before any cycle runs
   if (NUM_PERIPH < 1 || NUM_PERIPH > 16)
   begin : g_bad_periph
      $error("NUM_PERIPH must be 1 to 16");
   end
   if (WAKE_CYCLES < `WAKE_MIN_CYCLES || WAKE_CYCLES > `WAKE_MAX_CYCLES)
   begin : g_bad_wake
      $error("WAKE_CYCLES must be 2 to 4");
   end

   sleep_idle_power_manager_pkg::power_state_e state_reg;
   sleep_idle_power_manager_pkg::power_state_e state_next;

   // Register state
   logic                  regulator_keep_active_reg;
   logic [2:0]            new_osc_select_reg;
   logic [2:0]            cur_osc_reg;
   logic                  clk_lock_reg;
   logic                  low_power_regulator_en_reg;
   logic                  wdt_en_reg;
   logic                  clock_fail_monitor_reg;
   logic                  timer_one_stop_reg;
   logic [NUM_PERIPH-1:0] stop_in_halt_reg;
   logic                  mode_sleep_reg;
   logic                  wake_irq_reg;
   logic                  wake_wdt_reg;

   // Bus pipeline
   logic                  wr_pend_reg;
   logic [7:0]            wr_addr_reg;
   logic [31:0]           hrdata_reg;

   // Decoded signals
   logic                  addr_phase_w;
   logic [7:0]            rd_addr_w;
   logic [31:0]           rd_data_w;
   logic                  wr_rst_ctrl_w;
   logic                  wr_osc_ctrl_w;
   logic                  wr_pwr_cfg_w;
   logic                  wr_tmr_one_w;
   logic                  wr_stop_w;
   logic                  is_sleep_w;
   logic                  is_idle_w;
   logic                  save_req_w;
   logic                  wake_w;
   logic                  wake_done_w;
   logic                  wake_start_w;
   logic                  osc_change_w;
   logic                  in_sleep_w;
   logic                  in_idle_w;
   logic [NUM_PERIPH-1:0] stop_bits_w;

   // Zero-wait slave: every transfer completes at once with OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_reg;

   // Address phase accepted on a selected NONSEQ or SEQ with bus ready
   assign addr_phase_w = hsel_i && hready_i && htrans_i[`HTRANS_ACTIVE_BIT];
   assign rd_addr_w    = haddr_i[7:0];

   // Write strobes are taken in the data phase, when hwdata is valid
   assign wr_rst_ctrl_w = wr_pend_reg && (wr_addr_reg == `RESET_CONTROL_OFS);
   assign wr_osc_ctrl_w = wr_pend_reg && (wr_addr_reg == `OSC_CONTROL_OFS);
   assign wr_pwr_cfg_w  = wr_pend_reg && (wr_addr_reg == `POWER_CONFIG_OFS);
   assign wr_tmr_one_w  = wr_pend_reg && (wr_addr_reg == `TIMER_ONE_CONTROL_OFS);
   assign wr_stop_w     = wr_pend_reg && (wr_addr_reg == `PERIPH_STOP_OFS);

   // Read mux; unmapped addresses and reserved bits read as zero
   always_comb
   begin
      rd_data_w = `WORD_ZERO;
      unique case (rd_addr_w)
         `RESET_CONTROL_OFS:
         begin
            rd_data_w[`REG_KEEP_BIT] = regulator_keep_active_reg;
         end
         `OSC_CONTROL_OFS:
         begin
            rd_data_w[`NEW_OSC_MSB:`NEW_OSC_LSB] = new_osc_select_reg;
            rd_data_w[`CUR_OSC_MSB:`CUR_OSC_LSB] = cur_osc_reg;
            rd_data_w[`CLK_LOCK_BIT]             = clk_lock_reg;
         end
         `POWER_CONFIG_OFS:
         begin
            rd_data_w[`LP_REG_EN_BIT]  = low_power_regulator_en_reg;
            rd_data_w[`WDT_EN_BIT]     = wdt_en_reg;
            rd_data_w[`CLK_MON_EN_BIT] = clock_fail_monitor_reg;
         end
         `TIMER_ONE_CONTROL_OFS:
         begin
            rd_data_w[`TIMER_ONE_STOP_BIT] = timer_one_stop_reg;
         end
         `PERIPH_STOP_OFS:
         begin
            rd_data_w[NUM_PERIPH-1:0] = stop_bits_w;
         end
         `POWER_STATUS_OFS:
         begin
            rd_data_w[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_reg;
            rd_data_w[`STAT_OSC_MSB:`STAT_OSC_LSB]     = cur_osc_reg;
            rd_data_w[`STAT_WAKE_IRQ_BIT]              = wake_irq_reg;
            rd_data_w[`STAT_WAKE_WDT_BIT]              = wake_wdt_reg;
            rd_data_w[`STAT_LAST_SLEEP_BIT]            = mode_sleep_reg;
         end
         default:
         begin
            rd_data_w = `WORD_ZERO;
         end
      endcase
   end

   // Bus pipeline: read data is registered in the address phase
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg  <= `WORD_ZERO;
      end
      else
      begin
         wr_pend_reg <= addr_phase_w && hwrite_i;
         wr_addr_reg <= rd_addr_w;
         hrdata_reg  <= (addr_phase_w && !hwrite_i) ? rd_data_w : `WORD_ZERO;
      end
   end

   // Control registers written by software
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         regulator_keep_active_reg  <= 1'b0;
         low_power_regulator_en_reg <= 1'b0;
         wdt_en_reg                 <= 1'b0;
         clock_fail_monitor_reg     <= 1'b0;
         timer_one_stop_reg         <= 1'b0;
      end
      else
      begin
         if (wr_rst_ctrl_w)
         begin
            regulator_keep_active_reg <= hwdata_i[`REG_KEEP_BIT];
         end
         if (wr_pwr_cfg_w)
         begin
            low_power_regulator_en_reg <= hwdata_i[`LP_REG_EN_BIT];
            wdt_en_reg                 <= hwdata_i[`WDT_EN_BIT];
            clock_fail_monitor_reg     <= hwdata_i[`CLK_MON_EN_BIT];
         end
         if (wr_tmr_one_w)
         begin
            timer_one_stop_reg <= hwdata_i[`TIMER_ONE_STOP_BIT];
         end
      end
   end

   // peripheral stop bits; bit 0 is timer one and shares its control bit
   generate
      for (genvar p = 0; p < NUM_PERIPH; p++)
      begin : g_stop
         if (p == 0)
         begin : g_timer
            // Own flop unused: one process per bit avoids mixing driver kinds
            always_ff @(posedge sys_clk_i)
            begin
               stop_in_halt_reg[p] <= 1'b0;
            end
            assign stop_bits_w[p] = timer_one_stop_reg;
         end
         else
         begin : g_other
            always_ff @(posedge sys_clk_i)
            begin
               if (!rstn_i)
               begin
                  stop_in_halt_reg[p] <= 1'b0;
               end
               else if (wr_stop_w)
               begin
                  stop_in_halt_reg[p] <= hwdata_i[p];
               end
            end
            assign stop_bits_w[p] = stop_in_halt_reg[p];
         end
      end
   endgenerate

   // switch allowed only while unlocked and the core is running
   assign osc_change_w = wr_osc_ctrl_w && !clk_lock_reg
                         && (state_reg == sleep_idle_power_manager_pkg::ST_RUN);

   // Oscillator control; the lock is set-only so a runaway write cannot undo it
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         new_osc_select_reg <= `OSC_RESET;
         cur_osc_reg        <= `OSC_RESET;
         clk_lock_reg       <= 1'b0;
      end
      else if (osc_change_w)
      begin
         new_osc_select_reg <= hwdata_i[`NEW_OSC_MSB:`NEW_OSC_LSB];
         cur_osc_reg        <= hwdata_i[`NEW_OSC_MSB:`NEW_OSC_LSB];
         clk_lock_reg       <= hwdata_i[`CLK_LOCK_BIT];
      end
   end

   // operand decode; other operands do nothing
   assign is_sleep_w = (power_save_operand_i == `SLEEP_OPERAND);
   assign is_idle_w  = (power_save_operand_i == `IDLE_OPERAND);
   assign save_req_w = power_save_instr_i && (is_sleep_w || is_idle_w);
   // wake sources; device reset acts through rstn_i
   assign wake_w     = irq_wake_i || wdt_timeout_i;

   // Power state sequence
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         sleep_idle_power_manager_pkg::ST_RUN:
         begin
            if (save_req_w)
            begin
               state_next = sleep_idle_power_manager_pkg::ST_ENTER;
            end
         end
         // entry completes before any wake is looked at
         sleep_idle_power_manager_pkg::ST_ENTER:
         begin
            state_next = mode_sleep_reg ? sleep_idle_power_manager_pkg::ST_SLEEP
                                        : sleep_idle_power_manager_pkg::ST_IDLE;
         end
         sleep_idle_power_manager_pkg::ST_SLEEP,
         sleep_idle_power_manager_pkg::ST_IDLE:
         begin
            if (wake_w)
            begin
               state_next = sleep_idle_power_manager_pkg::ST_WAKE;
            end
         end
         // delayed return of the CPU clock
         sleep_idle_power_manager_pkg::ST_WAKE:
         begin
            if (wake_done_w)
            begin
               state_next = sleep_idle_power_manager_pkg::ST_RUN;
            end
         end
         default:
         begin
            state_next = sleep_idle_power_manager_pkg::ST_RUN;
         end
      endcase
   end

   assign wake_start_w = (state_next == sleep_idle_power_manager_pkg::ST_WAKE)
                         && (state_reg != sleep_idle_power_manager_pkg::ST_WAKE);

   // State, selected mode and wake cause
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         state_reg      <= sleep_idle_power_manager_pkg::ST_RUN;
         mode_sleep_reg <= 1'b0;
         wake_irq_reg   <= 1'b0;
         wake_wdt_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == sleep_idle_power_manager_pkg::ST_RUN && save_req_w)
         begin
            mode_sleep_reg <= is_sleep_w;
         end
         if (wake_start_w)
         begin
            wake_irq_reg <= irq_wake_i;
            wake_wdt_reg <= wdt_timeout_i;
         end
      end
   end

   wake_delay_timer
   #(
      .CYCLES (WAKE_CYCLES)
   )
   u_wake_delay
   (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .start_i   (wake_start_w),
      .done_o    (wake_done_w)
   );

   assign in_sleep_w = (state_reg == sleep_idle_power_manager_pkg::ST_SLEEP);
   assign in_idle_w  = (state_reg == sleep_idle_power_manager_pkg::ST_IDLE);

   // interrupts held off while entry is in progress
   assign irq_hold_o    = (state_reg == sleep_idle_power_manager_pkg::ST_ENTER);
   // CPU halted in every state but run
   assign core_halted_o = (state_reg != sleep_idle_power_manager_pkg::ST_RUN);
   assign cpu_clk_en_o  = (state_reg == sleep_idle_power_manager_pkg::ST_RUN);

   // watchdog cleared in the entry cycle, except entry to Sleep with the watchdog disabled
   assign wdt_clear_o = (state_reg == sleep_idle_power_manager_pkg::ST_ENTER)
                        && (!mode_sleep_reg || wdt_en_reg);

   // system clock and on-chip oscillator stop only in Sleep
   assign sys_clk_en_o = !in_sleep_w;
   assign osc_en_o     = !(in_sleep_w && ONCHIP_OSC[cur_osc_reg]);
   // source is frozen outside run, so wake restarts on it
   assign osc_select_o = cur_osc_reg;

   // monitor off throughout Sleep, whether or not the source is stopped
   assign clock_fail_monitor_en_o = clock_fail_monitor_reg && !in_sleep_w;
   // low-power RC clock kept for its users
   assign low_power_rc_clock_en_o = wdt_en_reg || (!in_sleep_w && clock_fail_monitor_reg);

   assign regulator_standby_o   = in_sleep_w && !regulator_keep_active_reg;
   assign low_power_regulator_o = in_sleep_w && low_power_regulator_en_reg;

   assign periph_clk_en_o = in_sleep_w ? ext_clk_periph_i
                          : in_idle_w  ? ~stop_bits_w
                          : {NUM_PERIPH{1'b1}};

   // Size is ignored and only full word addresses are decoded; a narrower access acts on the word only at its word-aligned address
   logic unused_w;
   assign unused_w = ^{haddr_i[31:8], hsize_i, htrans_i[0]};

endmodule : sleep_idle_power_manager

//--- tb/sleep_idle_power_manager_monitor.sv
// Port checker for the power manager, bound into the design top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module sleep_idle_power_manager_monitor
#(
   parameter int         NUM_PERIPH = 8,
   parameter logic [7:0] ONCHIP_OSC = 8'hff
)
(
   input wire logic                  sys_clk_i,
   input wire logic                  rstn_i,
   input wire logic                  power_save_instr_i,
   input wire logic [7:0]            power_save_operand_i,
   input wire logic                  irq_wake_i,
   input wire logic                  wdt_timeout_i,
   input wire logic                  irq_hold_o,
   input wire logic                  core_halted_o,
   input wire logic                  cpu_clk_en_o,
   input wire logic [NUM_PERIPH-1:0] ext_clk_periph_i,
   input wire logic                  sys_clk_en_o,
   input wire logic                  osc_en_o,
   input wire logic [2:0]            osc_select_o,
   input wire logic                  clock_fail_monitor_en_o,
   input wire logic                  low_power_rc_clock_en_o,
   input wire logic                  wdt_clear_o,
   input wire logic [NUM_PERIPH-1:0] periph_clk_en_o,
   input wire logic                  regulator_standby_o,
   input wire logic                  low_power_regulator_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // Accepted instruction, then the single entry cycle
   sequence take_s;
      power_save_instr_i && cpu_clk_en_o && power_save_operand_i < 8'h02;
   endsequence
   sequence enter_s;
      irq_hold_o && core_halted_o && !cpu_clk_en_o ##1 !irq_hold_o && core_halted_o;
   endsequence

   chk_entry_taken: assert property (take_s |=> enter_s)
      else $error("entry did not follow the instruction");
   chk_bad_operand: assert property (power_save_instr_i && cpu_clk_en_o &&
      power_save_operand_i > 8'h01 |=> cpu_clk_en_o && !core_halted_o)
      else $error("unknown operand changed the mode");
   chk_sleep_halt: assert property (!sys_clk_en_o |-> core_halted_o &&
      !cpu_clk_en_o && !clock_fail_monitor_en_o)
      else $error("sleep left core or monitor running");
   chk_sleep_osc: assert property (!sys_clk_en_o |->
      osc_en_o == !ONCHIP_OSC[osc_select_o])
      else $error("oscillator enable wrong in sleep");
   chk_sleep_periph: assert property (!sys_clk_en_o |->
      periph_clk_en_o == ext_clk_periph_i)
      else $error("peripheral clocks wrong in sleep");
   chk_wdt_clear: assert property (wdt_clear_o |-> irq_hold_o ##1 !wdt_clear_o)
      else $error("watchdog clear outside the entry cycle");
   chk_wake_bound: assert property (core_halted_o && !irq_hold_o &&
      (irq_wake_i || wdt_timeout_i) |-> ##[1:5] cpu_clk_en_o)
      else $error("wake did not return the cpu clock");
   chk_wake_early: assert property ($rose(core_halted_o) |-> !cpu_clk_en_o [*4])
      else $error("cpu clock came back too soon");
   chk_rc_monitor: assert property (clock_fail_monitor_en_o |-> low_power_rc_clock_en_o)
      else $error("monitor running without the rc clock");
   chk_run_power: assert property (cpu_clk_en_o |-> sys_clk_en_o && osc_en_o &&
      !regulator_standby_o && !low_power_regulator_o && &periph_clk_en_o)
      else $error("run mode with power reduced");
   chk_halt_osc: assert property (core_halted_o |=> $stable(osc_select_o))
      else $error("clock source changed while halted");
endmodule : sleep_idle_power_manager_monitor

bind sleep_idle_power_manager sleep_idle_power_manager_monitor
   #(.NUM_PERIPH(NUM_PERIPH), .ONCHIP_OSC(ONCHIP_OSC)) i_monitor
   (.sys_clk_i, .rstn_i, .power_save_instr_i, .power_save_operand_i, .irq_wake_i,
    .wdt_timeout_i, .irq_hold_o, .core_halted_o, .cpu_clk_en_o, .ext_clk_periph_i,
    .sys_clk_en_o, .osc_en_o, .osc_select_o, .clock_fail_monitor_en_o,
    .low_power_rc_clock_en_o, .wdt_clear_o, .periph_clk_en_o, .regulator_standby_o,
    .low_power_regulator_o);

//--- tb/core_model.sv
// Behavioural CPU core: issues power-save instructions and wake events.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module core_model
(
   input  wire logic  sys_clk_i,
   input  wire logic  cpu_clk_en_i,
   output logic       instr_o,
   output logic [7:0] operand_o,
   output logic       irq_o,
   output logic       wdt_o
);
   initial
   begin
      instr_o = 1'b0;
      operand_o = 8'h5a;
      irq_o = 1'b0;
      wdt_o = 1'b0;
   end

   task automatic issue(input logic [7:0] op, input logic with_irq);
      instr_o <= 1'b1;
      operand_o <= op;
      irq_o <= with_irq;
      @(posedge sys_clk_i);
      #1;
      instr_o <= 1'b0;
      operand_o <= ~op;  // Operand is not held past the pulse
   endtask : issue

   // Wake source stays pending until the cpu clock returns, as a real one would
   task automatic wake(input logic by_wdt, output int n);
      if (by_wdt)
         wdt_o <= 1'b1;
      else
         irq_o <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      while (!cpu_clk_en_i && n < 50);
      irq_o <= 1'b0;
      wdt_o <= 1'b0;
   endtask : wake
endmodule : core_model

//--- tb/sleep_idle_power_manager_tb.sv
// Self-checking bench: bus master tasks, core model and random configurations.
// Assumes the map header is on the include path and the checker is bound.
`timescale 1ns/1ps
`include "sleep_idle_power_manager_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sleep_idle_power_manager_tb;
   localparam int         NP  = 8;
   localparam int         WC  = 2;      // Shortest legal wake delay
   localparam logic [7:0] ONC = 8'h0f;  // Sources 0..3 on-chip, others external
   logic          sys_clk_i, rstn_i, hsel, hwrite, hrdy, hresp, rdy_q, sl, bw;
   logic          instr, irq, wdt, irq_hold, halted, cpu_en, sys_en, osc_en;
   logic          mon, low_power_rc_clock, wclr, reg_sb, lp_reg;
   logic [31:0]   haddr, hwdata, hrdata, rd_q, r, v;
   logic [1:0]    htrans;
   logic [2:0]    hsize, osc_sel, sel;
   logic [7:0]    operand;
   logic [NP-1:0] ext, pclk;
   int            errors, tests_run, seed, clr_cnt, c0, n;

   sleep_idle_power_manager #(.NUM_PERIPH(NP), .WAKE_CYCLES(WC), .ONCHIP_OSC(ONC)) i_dut
   (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .power_save_instr_i(instr), .power_save_operand_i(operand), .irq_wake_i(irq),
    .wdt_timeout_i(wdt), .irq_hold_o(irq_hold), .core_halted_o(halted),
    .cpu_clk_en_o(cpu_en), .ext_clk_periph_i(ext), .sys_clk_en_o(sys_en),
    .osc_en_o(osc_en), .osc_select_o(osc_sel), .clock_fail_monitor_en_o(mon),
    .low_power_rc_clock_en_o(low_power_rc_clock), .wdt_clear_o(wclr), .periph_clk_en_o(pclk),
    .regulator_standby_o(reg_sb), .low_power_regulator_o(lp_reg));

   core_model i_core
   (.sys_clk_i(sys_clk_i), .cpu_clk_en_i(cpu_en), .instr_o(instr), .operand_o(operand),
    .irq_o(irq), .wdt_o(wdt));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // Sample bus answers at the edge itself, and count clear pulses
   always @(posedge sys_clk_i)
   begin
      rd_q <= hrdata;
      rdy_q <= hrdy;
      if (wclr === 1'b1)
         clr_cnt <= clr_cnt + 1;
   end

   function automatic logic [31:0] exp_stat(input logic s, input logic w, input logic [2:0] c);
      return {21'h0, s, w, !w, 1'b0, c, 4'h0};
   endfunction : exp_stat

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do begin @(posedge sys_clk_i); #1; end while (!rdy_q);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge sys_clk_i); #1; end while (!rdy_q);
      r = rd_q;
   endtask : bus

   task automatic do_reset();
      rstn_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      #1 rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      #1;
   endtask : do_reset

   task automatic conclude();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // Under 270 cycles are needed; allow over a hundred times that
   initial
   begin
      #3_000_000;
      errors++;
      conclude();
   end

   initial
   begin
      seed = 32'h5006;
      {errors, tests_run, clr_cnt} = '0;
      {rstn_i, hsel, hwrite, hwdata, haddr, htrans, ext} = '0;
      hsize = 3'h2;
      do_reset();
      `CHK({cpu_en, halted, sys_en, osc_en, pclk}, {4'b1011, {NP{1'b1}}})
      // All registers zero after reset; 0x18 is unmapped
      for (int a = 0; a <= 8'h18; a += 4)
      begin
         bus(1'b0, a[7:0], 32'h0);
         `CHK({hresp, r}, 33'h0)
      end
      sel = $random(seed);
      bus(1'b1, `OSC_CONTROL_OFS, {21'h0, sel, 8'h0});
      `CHK(osc_sel, sel)
      // Every regulator pair, both modes, both wake causes
      for (int k = 0; k < 8; k++)
      begin
         v = $random(seed);
         ext <= v[NP-1:0];
         sl = !k[2];
         bw = k[0] ^ k[1];
         bus(1'b1, `RESET_CONTROL_OFS, {23'h0, k[1], 8'h0});
         bus(1'b1, `POWER_CONFIG_OFS, {29'h0, v[10:9], k[0]});
         bus(1'b1, `TIMER_ONE_CONTROL_OFS, {18'h0, v[11], 13'h0});
         bus(1'b1, `PERIPH_STOP_OFS, {24'h0, v[19:13], 1'b0});
         bus(1'b0, `PERIPH_STOP_OFS, 32'h0);
         `CHK(r[7:0], {v[19:13], v[11]})
         c0 = clr_cnt;
         i_core.issue(sl ? `SLEEP_OPERAND : `IDLE_OPERAND, 1'b0);
         @(posedge sys_clk_i);
         #1;
         `CHK(clr_cnt - c0, int'(sl ? v[9] : 1'b1))
         `CHK({cpu_en, halted, sys_en, mon}, {2'b01, !sl, !sl & v[10]})
         `CHK(osc_en, !(sl & ONC[sel]))
         `CHK(low_power_rc_clock, v[9] | (!sl & v[10]))
         `CHK({reg_sb, lp_reg}, {sl & !k[1], sl & k[0]})
         `CHK(pclk, sl ? ext : ~{v[19:13], v[11]})
         repeat (v[23:21]) @(posedge sys_clk_i);
         #1;
         bus(1'b1, `OSC_CONTROL_OFS, {21'h0, ~sel, 8'h0});
         i_core.wake(bw, n);
         `CHK(n, WC + 1)
         `CHK(osc_sel, sel)
         bus(1'b0, `POWER_STATUS_OFS, 32'h0);
         `CHK(r, exp_stat(sl, bw, sel))
      end
      // Unknown operands are ignored
      repeat (3)
      begin
         v = $random(seed);
         i_core.issue(v[7:0] | 8'h02, 1'b0);
         @(posedge sys_clk_i);
         #1;
         `CHK({cpu_en, halted}, 2'b10)
      end
      // Interrupt arriving with the instruction wakes only after entry
      i_core.issue(`IDLE_OPERAND, 1'b1);
      `CHK({irq_hold, halted}, 2'b11)
      i_core.wake(1'b0, n);
      `CHK(n, WC + 2)
      // Reset during sleep wakes the device
      i_core.issue(`SLEEP_OPERAND, 1'b0);
      @(posedge sys_clk_i);
      #1;
      do_reset();
      `CHK({cpu_en, sys_en, halted, osc_sel}, 6'b110000)
      // Locked configuration refuses a source change
      bus(1'b1, `OSC_CONTROL_OFS, 32'h0000_0080);
      bus(1'b1, `OSC_CONTROL_OFS, 32'h0000_0500);
      bus(1'b0, `OSC_CONTROL_OFS, 32'h0);
      `CHK({osc_sel, r[10:7]}, 7'h01)
      conclude();
   end
endmodule : sleep_idle_power_manager_tb
